// ===== hw/ctec_edge_channel.sv
/*
 One level-sensitive edge channel: picks a source, applies polarity
 and reports whether the channel is asserted now.
 Assumes source levels synchronous to the clock.
*/
`timescale 1ns/1ps
module ctec_edge_channel (
   input wire ctec_pkg::ctec_sources_t src, // Candidate sources
   input wire ctec_pkg::ctec_chan_cfg_t cfg, // Select and polarity
   input wire logic pass, // Edges passed through
   output wire logic active // Channel asserted
);
   wire logic picked;
   assign picked = (cfg.sel == ctec_pkg::SRC_PIN_ONE) ? src.pin_one :
                   (cfg.sel == ctec_pkg::SRC_PIN_TWO) ? src.pin_two :
                   (cfg.sel == ctec_pkg::SRC_TIMER) ? src.timer :
                   src.compare;
   // Polarity low: channel asserts on the low level
   assign active = pass & (cfg.pol ? picked : ~picked);
endmodule

// ===== hw/ctec_pkg.sv
/*
 Package for the charge/time edge control block: register addresses,
 field positions, reset values and the small carrier types.
 Assumes an 8-bit register port with one-cycle read latency.
*/
package ctec_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   // Register addresses
   localparam logic [2:0] ADDR_LOW_CTRL = 3'h0;
   localparam logic [2:0] ADDR_HIGH_CTRL = 3'h1;
   localparam logic [2:0] ADDR_CUR_CTRL = 3'h2;
   localparam logic [2:0] ADDR_FLAG_THREE = 3'h3;
   localparam logic [2:0] ADDR_ENABLE_THREE = 3'h4;
   // Low control register fields
   localparam int LC_FLAG1 = 0;
   localparam int LC_FLAG2 = 1;
   localparam int LC_SEL1_LO = 2;
   localparam int LC_POL1 = 4;
   localparam int LC_SEL2_LO = 5;
   localparam int LC_POL2 = 7;
   // High control register fields
   localparam int HC_DISCHARGE = 1;
   localparam int HC_ORDER = 2;
   localparam int HC_EDGES_PASS = 3;
   localparam int HC_DELAY_MODE = 4;
   localparam int HC_UNIT_EN = 7;
   localparam logic [7:0] HC_WRITABLE = 8'h9e;
   // Current control fields
   localparam int CC_RANGE_LO = 0;
   localparam int CC_TRIM_LO = 2;
   localparam logic [1:0] RANGE_LOWEST = 2'h1;
   // Flag and enable register three
   localparam int F3_EVENT = 2;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // Source selector codes
   localparam logic [1:0] SRC_PIN_ONE = 2'h0;
   localparam logic [1:0] SRC_PIN_TWO = 2'h1;
   localparam logic [1:0] SRC_TIMER = 2'h2;
   localparam logic [1:0] SRC_COMPARE = 2'h3;

   typedef struct packed {
      logic pin_one;
      logic pin_two;
      logic timer;
      logic compare;
   } ctec_sources_t;

   typedef struct packed {
      logic [1:0] sel;
      logic pol;
   } ctec_chan_cfg_t;

   typedef struct packed {
      logic source_on;
      logic discharge;
      logic delay_mode;
      logic unit_on;
      logic [1:0] range;
      logic signed [5:0] trim;
   } ctec_analog_t;
endpackage

// ===== hw/ctec_top.sv
/*
 Charge/time edge control: edge status flags, current source gating,
 event flag and interrupt request, configuration register decode.
 Assumes a register port strobed synchronously to SYS_CLK and edge
 sources already synchronous to SYS_CLK.
*/
`timescale 1ns/1ps
module ctec_top (
   input wire logic SYS_CLK, // System clock, 125 MHz
   input wire logic RESET, // Synchronous reset, high
   input wire logic [2:0] ADDR, // Register address
   input wire logic [7:0] WDATA, // Write data
   input wire logic WR, // Write strobe
   input wire logic RD, // Read strobe
   output logic [7:0] RDATA, // Read data, cycle after RD
   input wire logic EDGE_PIN_ONE, // Edge pin one
   input wire logic EDGE_PIN_TWO, // Edge pin two
   input wire logic TIMER_OUT, // Timer edge source
   input wire logic COMPARE_OUT, // Compare edge source
   output logic SOURCE_ON, // Current source enable
   output logic DISCHARGE, // Discharge attached circuit
   output logic DELAY_MODE, // Delay generation mode
   output logic UNIT_ON, // Analog unit enabled
   output logic [1:0] CURRENT_RANGE, // Current range index
   output logic signed [5:0] CURRENT_TRIM, // Signed trim
   output logic RANGE_LOWEST, // Lowest range selected
   output logic IRQ // Interrupt request
);
   logic [7:0] low_r;
   logic [7:0] high_r;
   logic [7:0] cur_r;
   logic event_r;
   logic event_en_r;
   logic src_on_r;
   logic [7:0] rdata_r;
   logic [7:0] low_nxt;
   logic event_nxt;

   wire logic wr_low;
   wire logic wr_high;
   wire logic wr_cur;
   wire logic wr_flag;
   wire logic wr_en;
   wire logic unit_en;
   wire logic pass;
   wire logic order_en;
   wire logic act1;
   wire logic act2;
   wire logic flag1;
   wire logic flag2;
   wire logic set1;
   wire logic set2;
   wire logic src_on_now;
   wire logic [7:0] rd_mux;
   wire ctec_pkg::ctec_sources_t srcs;
   wire ctec_pkg::ctec_chan_cfg_t cfg1;
   wire ctec_pkg::ctec_chan_cfg_t cfg2;
   wire logic [1:0] range_w;
   wire logic signed [5:0] trim_w;
   wire logic lowest_w;

   assign wr_low = WR & (ADDR == ctec_pkg::ADDR_LOW_CTRL);
   assign wr_high = WR & (ADDR == ctec_pkg::ADDR_HIGH_CTRL);
   assign wr_cur = WR & (ADDR == ctec_pkg::ADDR_CUR_CTRL);
   assign wr_flag = WR & (ADDR == ctec_pkg::ADDR_FLAG_THREE);
   assign wr_en = WR & (ADDR == ctec_pkg::ADDR_ENABLE_THREE);

   assign unit_en = high_r[ctec_pkg::HC_UNIT_EN];
   assign pass = unit_en & high_r[ctec_pkg::HC_EDGES_PASS];
   assign order_en = high_r[ctec_pkg::HC_ORDER];

   assign srcs = '{pin_one: EDGE_PIN_ONE, pin_two: EDGE_PIN_TWO,
                   timer: TIMER_OUT, compare: COMPARE_OUT};
   // Channel config seen by hardware follows a write at once
   assign cfg1 = wr_low ?
      '{sel: WDATA[ctec_pkg::LC_SEL1_LO +: 2], pol: WDATA[ctec_pkg::LC_POL1]} :
      '{sel: low_r[ctec_pkg::LC_SEL1_LO +: 2], pol: low_r[ctec_pkg::LC_POL1]};
   assign cfg2 = wr_low ?
      '{sel: WDATA[ctec_pkg::LC_SEL2_LO +: 2], pol: WDATA[ctec_pkg::LC_POL2]} :
      '{sel: low_r[ctec_pkg::LC_SEL2_LO +: 2], pol: low_r[ctec_pkg::LC_POL2]};

   ctec_edge_channel u_ch1 (
      .src(srcs),
      .cfg(cfg1),
      .pass(pass),
      .active(act1)
   );

   ctec_edge_channel u_ch2 (
      .src(srcs),
      .cfg(cfg2),
      .pass(pass),
      .active(act2)
   );

   ctec_trim_decode u_trim (
      .cur_ctrl(cur_r),
      .range(range_w),
      .trim(trim_w),
      .range_lowest(lowest_w),
      .range_valid()
   );

   assign flag1 = low_r[ctec_pkg::LC_FLAG1];
   assign flag2 = low_r[ctec_pkg::LC_FLAG2];
   // Hardware set of each flag; edge two waits for edge one when ordered
   assign set1 = act1;
   assign set2 = act2 & (~order_en | flag1);

   // Software write stores fields; hardware set wins over a clear
   always_comb begin
      low_nxt = wr_low ? WDATA : low_r;
      low_nxt[ctec_pkg::LC_FLAG1] = low_nxt[ctec_pkg::LC_FLAG1] | set1;
      low_nxt[ctec_pkg::LC_FLAG2] = low_nxt[ctec_pkg::LC_FLAG2] | set2;
   end

   assign src_on_now = unit_en & (flag1 ^ flag2);

   always_comb begin
      event_nxt = event_r;
      if (wr_flag) begin
         event_nxt = WDATA[ctec_pkg::F3_EVENT];
      end
      if (src_on_r & ~src_on_now) begin
         event_nxt = 1'b1;
      end
   end

   assign rd_mux = (ADDR == ctec_pkg::ADDR_LOW_CTRL) ? low_r :
                   (ADDR == ctec_pkg::ADDR_HIGH_CTRL) ? high_r :
                   (ADDR == ctec_pkg::ADDR_CUR_CTRL) ? cur_r :
                   (ADDR == ctec_pkg::ADDR_FLAG_THREE) ?
                      (8'(event_r) << ctec_pkg::F3_EVENT) :
                   (ADDR == ctec_pkg::ADDR_ENABLE_THREE) ?
                      (8'(event_en_r) << ctec_pkg::F3_EVENT) :
                   ctec_pkg::READ_ZERO;

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         low_r <= ctec_pkg::REG_RESET;
         high_r <= ctec_pkg::REG_RESET;
         cur_r <= ctec_pkg::REG_RESET;
         event_r <= 1'b0;
         event_en_r <= 1'b0;
         src_on_r <= 1'b0;
         rdata_r <= ctec_pkg::READ_ZERO;
      end else begin
         low_r <= low_nxt;
         if (wr_high) begin
            high_r <= WDATA & ctec_pkg::HC_WRITABLE;
         end
         if (wr_cur) begin
            cur_r <= WDATA;
         end
         if (wr_en) begin
            event_en_r <= WDATA[ctec_pkg::F3_EVENT];
         end
         event_r <= event_nxt;
         src_on_r <= src_on_now;
         rdata_r <= RD ? rd_mux : ctec_pkg::READ_ZERO;
      end
   end

   assign RDATA = rdata_r;
   assign SOURCE_ON = src_on_r;
   assign DISCHARGE = unit_en & high_r[ctec_pkg::HC_DISCHARGE];
   assign DELAY_MODE = high_r[ctec_pkg::HC_DELAY_MODE];
   assign UNIT_ON = unit_en;
   assign CURRENT_RANGE = range_w;
   assign CURRENT_TRIM = trim_w;
   assign RANGE_LOWEST = lowest_w;
   assign IRQ = event_r & event_en_r;

   sequence s_src_on;
      src_on_r;
   endsequence
   sequence s_src_off;
      ~src_on_r;
   endsequence

   a_source_exactly_one: assert property (@(posedge SYS_CLK) disable iff (RESET)
      ##1 src_on_r == $past(unit_en & (flag1 ^ flag2)))
      else $error("source enable disagrees with flags");
   a_event_on_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
      s_src_on ##1 s_src_off |-> event_r)
      else $error("event flag not set after source off");
   a_irq_gating: assert property (@(posedge SYS_CLK) disable iff (RESET)
      IRQ == (event_r & event_en_r))
      else $error("interrupt not gated by enable");
   a_flag_one_set: assert property (@(posedge SYS_CLK) disable iff (RESET)
      act1 |=> flag1)
      else $error("edge one flag missed");
   a_order_block: assert property (@(posedge SYS_CLK) disable iff (RESET)
      order_en && !flag1 && !set1 && !flag2 && !(wr_low && WDATA[1])
      |=> !flag2)
      else $error("edge two accepted before edge one");
   a_edges_blocked: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !pass |-> !act1 && !act2)
      else $error("edge seen while blocked");
   a_sw_flag_write: assert property (@(posedge SYS_CLK) disable iff (RESET)
      wr_low && WDATA[1:0] == 2'h3 |=> flag1 && flag2 ##1 !src_on_r)
      else $error("software flag write ignored");
   a_unit_off: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !unit_en |-> !DISCHARGE ##1 !src_on_r)
      else $error("unit active while disabled");
endmodule

// ===== hw/ctec_trim_decode.sv
/*
 Current trim and range decode toward the analog current source.
 Assumes the analog side takes a signed step count and a range index.
*/
`timescale 1ns/1ps
module ctec_trim_decode (
   input wire logic [7:0] cur_ctrl, // Current control register
   output wire logic [1:0] range, // Range index, 1 is lowest
   output wire logic signed [5:0] trim, // Signed trim steps
   output wire logic range_lowest, // Lowest range selected
   output wire logic range_valid // Range field not zero
);
   assign range = cur_ctrl[ctec_pkg::CC_RANGE_LO +: 2];
   assign range_lowest = (range == ctec_pkg::RANGE_LOWEST);
   assign range_valid = (range != 2'h0);
   // Two's complement: 0 neutral, 1f max up, 20 max down
   assign trim = $signed(cur_ctrl[ctec_pkg::CC_TRIM_LO +: 6]);
endmodule

// ===== tb/ctec_src_model.sv
/*
 Far-side model: edge sources driven at commanded levels, and an
 analog current source whose charge grows while it is on.
 Assumes levels change just after a rising clock edge.
*/
`timescale 1ns/1ps
module ctec_src_model (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic [3:0] lvl, // Pin one, pin two, timer, compare
   input wire logic source_on, // Current source enable
   input wire logic discharge, // Discharge request
   output ctec_pkg::ctec_sources_t src, // Edge source levels
   output logic [7:0] charge_r // Charge on the attached circuit
);
   assign src = ctec_pkg::ctec_sources_t'(lvl);
   always_ff @(posedge clk) begin
      if (rst || discharge) begin
         charge_r <= 8'h00;
      end else if (source_on && charge_r != 8'hff) begin
         charge_r <= charge_r + 8'h01;
      end
   end
endmodule

// ===== tb/tb.sv
/*
 Self-checking bench for the edge control block: register port,
 edge flags, current gating, event flag and analog decode.
 Assumes the far-side model in ctec_src_model.
*/
`timescale 1ns/1ps
module tb;
   logic SYS_CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00, RDATA, charge, d;
   logic [3:0] lvl = 4'h0;
   logic SOURCE_ON, DISCHARGE, DELAY_MODE, UNIT_ON, RANGE_LOWEST, IRQ;
   logic [1:0] CURRENT_RANGE;
   logic signed [5:0] CURRENT_TRIM;
   ctec_pkg::ctec_sources_t src;
   int errors = 0, cmp_count = 0, cyc = 0;
   always #4 SYS_CLK = ~SYS_CLK;
   ctec_src_model far_u (.clk(SYS_CLK), .rst(RESET), .lvl(lvl),
      .source_on(SOURCE_ON), .discharge(DISCHARGE), .src(src),
      .charge_r(charge));
   ctec_top dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .EDGE_PIN_ONE(src.pin_one), .EDGE_PIN_TWO(src.pin_two),
      .TIMER_OUT(src.timer), .COMPARE_OUT(src.compare),
      .SOURCE_ON(SOURCE_ON), .DISCHARGE(DISCHARGE),
      .DELAY_MODE(DELAY_MODE), .UNIT_ON(UNIT_ON),
      .CURRENT_RANGE(CURRENT_RANGE), .CURRENT_TRIM(CURRENT_TRIM),
      .RANGE_LOWEST(RANGE_LOWEST), .IRQ(IRQ));
   task automatic final_report();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   endtask
   task automatic set_lvl(input logic [3:0] v, input int n);
      @(posedge SYS_CLK);
      lvl <= v;
      wt(n);
   endtask
   task automatic t_reset();
      foreach (d[i]) rd(3'(i), 8'h00);
      chk({2'b0, SOURCE_ON, DISCHARGE, DELAY_MODE, UNIT_ON, IRQ}, 0);
      wr(3'h1, 8'hff);
      rd(3'h1, ctec_pkg::HC_WRITABLE);
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h00);
      wr(3'h2, 8'h01);
      wr(3'h3, 8'h00);
      rd(3'h3, 8'h00);
   endtask
   task automatic t_block();
      wr(3'h1, 8'h80);
      rd(3'h0, 8'h00);
      wr(3'h1, 8'h88);
      rd(3'h0, 8'h03);
      chk({7'h0, SOURCE_ON}, 8'h00);
      wr(3'h1, 8'h08);
      wr(3'h0, 8'h91);
      wt(2);
      chk({7'h0, SOURCE_ON}, 8'h00);
      wr(3'h0, 8'h90);
   endtask
   task automatic t_soft();
      wr(3'h1, 8'h80);
      wr(3'h0, 8'h91);
      wt(1);
      chk({7'h0, SOURCE_ON}, 8'h01);
      wr(3'h0, 8'h93);
      wt(1);
      chk({7'h0, SOURCE_ON}, 8'h00);
      rd(3'h3, 8'h04);
      chk({7'h0, IRQ}, 8'h00);
      wr(3'h4, 8'h04);
      wt(0);
      chk({7'h0, IRQ}, 8'h01);
      wr(3'h0, 8'h90);
      wr(3'h3, 8'h00);
      wt(0);
      chk({7'h0, IRQ}, 8'h00);
   endtask
   task automatic t_sel();
      wr(3'h1, 8'h88);
      for (int s = 0; s < 4; s++) begin
         lvl <= 4'h8 >> s;
         wr(3'h0, {3'b101, 1'b1, 2'(s), 2'b00});
         rd(3'h0, {3'b101, 1'b1, 2'(s), 1'(s == 1), 1'b1});
         chk(RDATA & 8'h01, 8'h01);
         lvl <= 4'h0;
         wr(3'h0, 8'h90);
      end
   endtask
   task automatic t_edge();
      wr(3'h3, 8'h00);
      wr(3'h0, 8'hb0);
      set_lvl(4'h8, 2);
      chk({7'h0, SOURCE_ON}, 8'h01);
      set_lvl(4'hc, 2);
      chk({7'h0, SOURCE_ON}, 8'h00);
      chk(8'(charge != 8'h00), 8'h01);
      wr(3'h0, 8'hb0);
      rd(3'h0, 8'hb3);
      rd(3'h3, 8'h04);
      set_lvl(4'h0, 0);
      wr(3'h0, 8'hb0);
      wr(3'h3, 8'h00);
   endtask
   task automatic t_order();
      wr(3'h1, 8'h8c);
      set_lvl(4'h4, 3);
      rd(3'h0, 8'hb0);
      set_lvl(4'hc, 3);
      rd(3'h0, 8'hb3);
      set_lvl(4'h0, 0);
      wr(3'h0, 8'hb0);
   endtask
   task automatic t_analog();
      logic [7:0] v[3] = '{8'h01, 8'h7e, 8'h87};
      logic [2:0] lo[3] = '{3'b101, 3'b010, 3'b011};
      for (int i = 0; i < 3; i++) begin
         wr(3'h2, v[i]);
         wt(0);
         chk({CURRENT_TRIM, CURRENT_RANGE}, v[i]);
         chk({5'h0, RANGE_LOWEST, CURRENT_RANGE}, {5'h0, lo[i]});
      end
      wr(3'h1, 8'h92);
      wt(1);
      chk({5'h0, UNIT_ON, DELAY_MODE, DISCHARGE}, 8'h07);
      chk(charge, 8'h00);
      wr(3'h1, 8'h80);
      wt(0);
      chk({5'h0, UNIT_ON, DELAY_MODE, DISCHARGE}, 8'h04);
   endtask
   initial begin
      repeat (12) @(posedge SYS_CLK);
      RESET <= 1'b0;
      t_reset();
      t_block();
      t_soft();
      t_sel();
      t_edge();
      t_order();
      t_analog();
      final_report();
   end
endmodule
